// >>> rtl/acs_sequencer.v
// Conversion sequencer of an eight-channel 12-bit converter
`timescale 1ns/1ps
`include "acs_consts.vh"
module acs_sequencer #(
  parameter RW = `ACS_RESULT_W
) (
  // Clock and reset
  input  wire          clk_sys_in,
  input  wire          reset_in,
  // Parallel bus pins
  input  wire          cs_n_in,
  input  wire          wr_n_in,
  input  wire          rd_n_in,
  input  wire          upper_byte_sel_in,
  input  wire [7:0]    data_in,
  output reg  [7:0]    data_out,
  output reg           data_oe_out,
  output reg           done_n_out,
  // Conversion clock pins and shutdown
  input  wire          conv_clk_ext_in,
  input  wire          conv_clk_int_in,
  input  wire          hw_shutdown_n_in,
  // Analog core
  input  wire [RW-1:0] sar_result_in,
  output reg  [2:0]    chan_sel_out,
  output reg           span_sel_out,
  output reg           polarity_sel_out,
  output reg           track_out,
  output reg           converting_out,
  output reg           int_clk_sel_out,
  output reg           standby_powerdown_out,
  output reg           full_powerdown_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ACQI = 2'h1;
  localparam ST_ACQX = 2'h2;
  localparam ST_CONV = 2'h3;

  wire       cs_n_s;
  wire       wr_n_s;
  wire       rd_n_s;
  wire       upper_byte_sel_s;
  wire       hw_shutdown_n_n_s;
  wire       cke_s;
  wire       cki_s;

  acs_sync #(.W(5), .RST_V(1'b1)) u_sync_hi (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .pin_in     ({cs_n_in, wr_n_in, rd_n_in, hw_shutdown_n_in,
                  upper_byte_sel_in}),
    .level_out  ({cs_n_s, wr_n_s, rd_n_s, hw_shutdown_n_n_s, upper_byte_sel_s})
  );
  acs_sync #(.W(2), .RST_V(1'b0)) u_sync_ck (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .pin_in     ({conv_clk_ext_in, conv_clk_int_in}),
    .level_out  ({cke_s, cki_s})
  );

  // Data pins change slowly relative to strobes; hold copies
  // Three stages, one fewer than the strobes, so data settles before a rise
  reg  [7:0] data_d0_r;
  reg  [7:0] data_d1_r;
  reg  [7:0] data_d2_r;
  reg        wr_n_d_r;
  reg        rd_n_d_r;
  reg        cclk_d_r;
  reg  [1:0] state_r;
  reg  [3:0] cnt_r;
  reg  [7:0] ctrl_r;
  reg        pend_pd_r;
  reg  [1:0] pend_code_r;
  reg [RW-1:0] result_r;
  reg        res_bip_r;

  wire wr_d_fall = wr_n_d_r & ~wr_n_s;
  wire wr_fall = ~cs_n_s & wr_d_fall;
  wire wr_rise = ~cs_n_s & ~wr_n_d_r & wr_n_s;
  wire rd_fall = ~cs_n_s & rd_n_d_r & ~rd_n_s;
  wire cclk    = int_clk_sel_out ? cki_s : cke_s;
  wire cclk_up = cclk & ~cclk_d_r;
  wire [1:0] wcode = data_d2_r[`ACS_BIT_PWR_HI:`ACS_BIT_PWR_LO];
  wire       wacq  = data_d2_r[`ACS_BIT_ACQ_SRC];
  wire       pd_code = wcode[1];
  // Last clock of each timed phase, unless a write or shutdown cuts it
  wire       conv_end = hw_shutdown_n_n_s & ~wr_rise & cclk_up &
                        (state_r == ST_CONV) &
                        (cnt_r == `ACS_CONV_CYCLES - 4'h1);
  wire       acq_end  = hw_shutdown_n_n_s & ~wr_rise & cclk_up &
                        (state_r == ST_ACQI) &
                        (cnt_r == `ACS_ACQ_CYCLES - 4'h1);
  // Sign copy or zero above the four top result bits
  wire [3:0] upper_fill = {4{res_bip_r & result_r[RW-1]}};

  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      data_d0_r <= 8'h00;
      data_d1_r <= 8'h00;
      data_d2_r <= 8'h00;
      wr_n_d_r  <= 1'b1;
      rd_n_d_r  <= 1'b1;
      cclk_d_r  <= 1'b0;
    end else begin
      data_d0_r <= data_in;
      data_d1_r <= data_d0_r;
      data_d2_r <= data_d1_r;
      wr_n_d_r  <= wr_n_s;
      rd_n_d_r  <= rd_n_s;
      cclk_d_r  <= cclk;
    end
  end

  // Sequencer
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_r               <= ST_IDLE;
      ctrl_r                <= 8'h00;
      chan_sel_out          <= 3'h0;
      span_sel_out          <= 1'b0;
      polarity_sel_out      <= 1'b0;
      track_out             <= 1'b0;
      converting_out        <= 1'b0;
    end else if (!hw_shutdown_n_n_s) begin
      state_r               <= ST_IDLE;
      track_out             <= 1'b0;
      converting_out        <= 1'b0;
    end else begin
      if (wr_rise) begin
        ctrl_r     <= data_d2_r;
        chan_sel_out     <= data_d2_r[`ACS_CHAN_MSB:0];
        span_sel_out     <= data_d2_r[`ACS_BIT_SPAN];
        polarity_sel_out <= data_d2_r[`ACS_BIT_POLARITY];
        converting_out <= 1'b0;
        track_out      <= 1'b1;
        if (wacq) begin
          state_r <= ST_ACQX;
        end else if (state_r == ST_ACQX) begin
          state_r        <= ST_CONV;
          track_out      <= 1'b0;
          converting_out <= 1'b1;
        end else begin
          state_r <= ST_ACQI;
        end
      end else begin
        case (state_r)
          ST_ACQI: begin
            if (cclk_up) begin
              if (cnt_r == `ACS_ACQ_CYCLES - 4'h1) begin
                state_r        <= ST_CONV;
                track_out      <= 1'b0;
                converting_out <= 1'b1;
              end
            end
          end
          ST_CONV: begin
            if (cclk_up) begin
              if (cnt_r == `ACS_CONV_CYCLES - 4'h1) begin
                state_r        <= ST_IDLE;
                converting_out <= 1'b0;
              end
            end
          end
          ST_ACQX: begin
            track_out <= 1'b1;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Clock counter shared by timed acquisition and conversion
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_r <= 4'h0;
    end else if (!hw_shutdown_n_n_s || wr_rise || acq_end || conv_end) begin
      cnt_r <= 4'h0;
    end else if (cclk_up &&
                 (state_r == ST_ACQI || state_r == ST_CONV)) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Done flag; a finishing conversion beats a read clear
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      done_n_out <= 1'b1;
    end else if (conv_end) begin
      done_n_out <= 1'b0;
    end else if (rd_fall) begin
      done_n_out <= 1'b1;
    end else if (wr_rise && hw_shutdown_n_n_s) begin
      done_n_out <= 1'b1;
    end
  end

  // Power modes; power-down codes wait for the end of conversion
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      standby_powerdown_out <= 1'b0;
      full_powerdown_out    <= 1'b0;
      pend_pd_r             <= 1'b0;
      pend_code_r           <= 2'h0;
    end else if (!hw_shutdown_n_n_s) begin
      standby_powerdown_out <= 1'b0;
      full_powerdown_out    <= 1'b1;
      pend_pd_r             <= 1'b0;
    end else begin
      if (wr_fall) begin
        standby_powerdown_out <= 1'b0;
        full_powerdown_out    <= 1'b0;
      end
      if (wr_rise) begin
        pend_pd_r   <= pd_code;
        pend_code_r <= wcode;
      end else if (conv_end && pend_pd_r) begin
        standby_powerdown_out <=
          (pend_code_r == `ACS_PM_STANDBY);
        full_powerdown_out    <=
          (pend_code_r == `ACS_PM_FULL);
        pend_pd_r             <= 1'b0;
      end
    end
  end

  // Result capture at the last conversion clock
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      result_r  <= {RW{1'b0}};
      res_bip_r <= 1'b0;
    end else if (conv_end) begin
      result_r  <= sar_result_in;
      res_bip_r <= polarity_sel_out;
    end
  end

  // Clock source; power-down codes leave it alone
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      int_clk_sel_out <= 1'b0;
    end else if (hw_shutdown_n_n_s && wr_rise && !pd_code) begin
      int_clk_sel_out <= (wcode == `ACS_PM_INT_CLK);
    end
  end

  // Read path, alive in every power mode
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      data_out    <= 8'h00;
      data_oe_out <= 1'b0;
    end else begin
      data_oe_out <= ~cs_n_s & ~rd_n_s;
      if (upper_byte_sel_s) begin
        data_out <= {upper_fill, result_r[RW-1:8]};
      end else begin
        data_out <= result_r[7:0];
      end
    end
  end
endmodule

// >>> rtl/acs_consts.vh
// Constants for the conversion sequencer: control byte fields and counts
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
`define ACS_BIT_PWR_HI     7
`define ACS_BIT_PWR_LO     6
`define ACS_BIT_ACQ_SRC    5
`define ACS_BIT_SPAN       4
`define ACS_BIT_POLARITY   3
`define ACS_CHAN_MSB       2
`define ACS_PM_EXT_CLK     2'h0
`define ACS_PM_INT_CLK     2'h1
`define ACS_PM_STANDBY     2'h2
`define ACS_PM_FULL        2'h3
`define ACS_ACQ_CYCLES     4'h6
`define ACS_CONV_CYCLES    4'hC
`define ACS_RESULT_W       12
`endif

// >>> rtl/acs_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module acs_sync #(
  parameter W     = 1,
  parameter RST_V = 1'b0
) (
  // Clock and reset
  input  wire         clk_sys_in,
  input  wire         reset_in,
  // Pins
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] level_out
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
          s1_r[i]      <= RST_V;
          s2_r[i]      <= RST_V;
          s3_r[i]      <= RST_V;
          level_out[i] <= RST_V;
        end else begin
          s1_r[i] <= pin_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          // Change counts once second and third agree
          if (s2_r[i] == s3_r[i]) begin
            level_out[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate
endmodule

// >>> bench/acs_seq_properties.sv
// Pin-level checker for the conversion sequencer
`timescale 1ns/1ps
module acs_seq_chk (
  // Clock and reset
  input wire clk_sys_in,
  input wire reset_in,
  // Bus and shutdown pins
  input wire cs_n_in,
  input wire rd_n_in,
  input wire hw_shutdown_n_in,
  // Observed outputs
  input wire data_oe_out,
  input wire done_n_out,
  input wire track_out,
  input wire converting_out,
  input wire int_clk_sel_out,
  input wire standby_powerdown_out,
  input wire full_powerdown_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  oe_deselect_a: assert property (cs_n_in[*8] |-> !data_oe_out)
    else $error("data pins driven while deselected");
  one_phase_a: assert property (!(track_out && converting_out))
    else $error("tracking and converting together");
  conv_length_a: assert property ($rose(converting_out) |->
    converting_out[*8]) else $error("conversion ended early");
  done_cause_a: assert property ($fell(done_n_out) |->
    $past(converting_out, 2)) else $error("done without conversion");
  read_clear_a: assert property ((!cs_n_in && !rd_n_in)[*7] |->
    done_n_out) else $error("done not cleared by read");
  oe_read_a: assert property ((!cs_n_in && !rd_n_in)[*7] |->
    data_oe_out) else $error("data pins not driven on read");
  shutdown_a: assert property ((!hw_shutdown_n_in)[*8] |->
    full_powerdown_out && !converting_out)
    else $error("shutdown pin not obeyed");
  pd_clock_a: assert property ($rose(standby_powerdown_out) ||
    $rose(full_powerdown_out) |-> $stable(int_clk_sel_out))
    else $error("power-down changed clock source");
  pd_wait_a: assert property ($rose(standby_powerdown_out) |->
    $past(converting_out)) else $error("standby before conversion end");
  cover property ($fell(done_n_out));
  cover property ($rose(standby_powerdown_out));
  cover property ($fell(converting_out) && track_out);
endmodule
bind acs_sequencer acs_seq_chk i_chk (.clk_sys_in, .reset_in, .cs_n_in,
  .rd_n_in, .hw_shutdown_n_in, .data_oe_out, .done_n_out, .track_out,
  .converting_out, .int_clk_sel_out, .standby_powerdown_out,
  .full_powerdown_out);

// >>> bench/acs_host.sv
// Host processor model on the 8-bit parallel port
`timescale 1ns/1ps
module acs_host (
  // Clock
  input  wire              clk_sys_in,
  // Bus pins
  input  wire        [7:0] rd_data_in,
  output logic             cs_n_out = 1'b1,
  output logic             wr_n_out = 1'b1,
  output logic             rd_n_out = 1'b1,
  output logic             ub_out = 1'b0,
  output logic       [7:0] wdata_out = 8'hFF
);
  // Write cycle: data held well around the rising strobe
  task automatic wr(input logic [7:0] v);
    @(posedge clk_sys_in);
    cs_n_out <= 1'b0;
    wdata_out <= v;
    @(posedge clk_sys_in);
    wr_n_out <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    wr_n_out <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    cs_n_out <= 1'b1;
    wdata_out <= ~v;
    repeat (6) @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic ub, output logic [7:0] v);
    @(posedge clk_sys_in);
    cs_n_out <= 1'b0;
    ub_out <= ub;
    rd_n_out <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    v = rd_data_in;
    rd_n_out <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    cs_n_out <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
  endtask
endmodule

// >>> bench/tb.sv
// Testbench for the conversion sequencer
`timescale 1ns/1ps
module tb;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, conv_clk_ext_in = 1'b0;
  logic conv_clk_int_in = 1'b0, hw_shutdown_n_in = 1'b1;
  logic [11:0] sar_result_in = 12'h9A5;
  logic [7:0] v;
  wire cs_n_in, wr_n_in, rd_n_in, upper_byte_sel_in, data_oe_out, done_n_out;
  wire track_out, converting_out, int_clk_sel_out, span_sel_out;
  wire polarity_sel_out, standby_powerdown_out, full_powerdown_out;
  wire [7:0] data_in, data_out;
  wire [2:0] chan_sel_out;
  int fail_count = 0, n_checks = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  always #250 conv_clk_ext_in = ~conv_clk_ext_in;
  always #320 conv_clk_int_in = ~conv_clk_int_in;
  acs_host i_host (.clk_sys_in, .rd_data_in(data_out), .cs_n_out(cs_n_in),
    .wr_n_out(wr_n_in), .rd_n_out(rd_n_in), .ub_out(upper_byte_sel_in),
    .wdata_out(data_in));
  acs_sequencer i_dut (.clk_sys_in, .reset_in, .cs_n_in, .wr_n_in, .rd_n_in,
    .upper_byte_sel_in, .data_in, .data_out, .data_oe_out, .done_n_out,
    .conv_clk_ext_in, .conv_clk_int_in, .hw_shutdown_n_in, .sar_result_in,
    .chan_sel_out, .span_sel_out, .polarity_sel_out, .track_out,
    .converting_out, .int_clk_sel_out, .standby_powerdown_out,
    .full_powerdown_out);
  task automatic chk(input string n, input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Wait for conversion start (c=1) or done low (c=0)
  task automatic wt(input bit c);
    int i;
    i = 0;
    while ((c ? converting_out : ~done_n_out) !== 1'b1 && i < 5000) begin
      @(posedge clk_sys_in);
      i++;
    end
    if (i == 5000) chk("wait", 8'h00, 8'h01);
    @(posedge clk_sys_in);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    fail_count++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    chk("done", done_n_out, 1);
    chk("intclk", int_clk_sel_out, 0);
    i_host.wr(8'h0D);
    chk("track", track_out, 1);
    chk("cfg", {span_sel_out, polarity_sel_out, chan_sel_out}, 8'h0D);
    wt(1);
    chk("track", track_out, 0);
    wt(0);
    chk("done", done_n_out, 0);
    i_host.rd(1'b0, v);
    chk("low", v, 8'hA5);
    chk("done", done_n_out, 1);
    i_host.rd(1'b1, v);
    chk("high", v, 8'hF9);
    sar_result_in <= 12'h3C6;
    i_host.wr(8'h30);
    repeat (1000) @(posedge clk_sys_in);
    chk("track", track_out, 1);
    i_host.wr(8'h30);
    repeat (1000) @(posedge clk_sys_in);
    chk("track", track_out, 1);
    i_host.wr(8'h50);
    chk("conv", converting_out, 1);
    chk("intclk", int_clk_sel_out, 1);
    wt(0);
    i_host.rd(1'b1, v);
    chk("high", v, 8'h03);
    i_host.wr(8'h40);
    wt(1);
    i_host.wr(8'h40);
    chk("track", track_out, 1);
    chk("conv", converting_out, 0);
    wt(0);
    i_host.wr(8'h80);
    chk("done", done_n_out, 1);
    chk("stby", standby_powerdown_out, 0);
    wt(0);
    chk("stby", standby_powerdown_out, 1);
    chk("intclk", int_clk_sel_out, 1);
    i_host.rd(1'b0, v);
    chk("low", v, 8'hC6);
    i_host.wr(8'h00);
    chk("stby", standby_powerdown_out, 0);
    chk("intclk", int_clk_sel_out, 0);
    wt(1);
    repeat (20) @(posedge clk_sys_in);
    hw_shutdown_n_in <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    chk("full", full_powerdown_out, 1);
    chk("conv", converting_out, 0);
    hw_shutdown_n_in <= 1'b1;
    i_host.wr(8'h00);
    chk("full", full_powerdown_out, 0);
    final_report();
  end
endmodule
